/* design/acq_cfg_pkg.sv */
package acq_cfg_pkg;

    // register map, printed offsets used as plain port addresses
    localparam logic [7:0] ACQ_CFG_ADDR = 8'h62;
    localparam logic [7:0] BAL_DLY_ADDR = 8'h63;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h70;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h71;
    localparam logic [7:0] DIAG_STATE_ADDR = 8'h72;

    // acquisition_config fields
    localparam int STUCK_EN_BIT = 15;
    localparam int CAL_EN_BIT = 14;
    localparam int COMP_EN_BIT = 13;
    localparam int OSR_LSB = 11;
    localparam int THERMISTOR_BIAS_PIN_LSB = 9;
    localparam int GAIN_LSB = 6;
    localparam logic [15:0] ACQ_CFG_WMASK = 16'hffc0;
    localparam logic [15:0] ACQ_CFG_RESET = 16'h0000;
    localparam logic [15:0] BAL_DLY_RESET = 16'h0000;

    // scan configuration codes
    localparam logic [2:0] SCAN_COMP_ONLY = 3'h2;
    localparam logic [2:0] SCAN_BOTH = 3'h1;

    // converter stuck-test expected codes
    localparam logic [11:0] ZERO_SCALE_CODE = 12'h000;
    localparam logic [11:0] FULL_SCALE_CODE = 12'hfff;

    // interrupt status bit positions
    localparam int IRQ_ZS = 0;
    localparam int IRQ_FS = 1;
    localparam int IRQ_OV = 2;
    localparam int IRQ_UV = 3;

    // timing
    localparam int CLK_HZ = 200_000_000;
    localparam int STEP_US = 96;
    localparam int STEP_CYC = CLK_HZ / 1_000_000 * STEP_US;
    localparam int RATE_50_HZ = 1600;
    localparam int RATE_60_HZ = 1920;
    localparam int RATE_50_CYC = CLK_HZ / RATE_50_HZ;
    localparam int RATE_60_CYC = CLK_HZ / RATE_60_HZ;

    typedef enum logic [1:0] {
        DLY_IDLE = 2'b00,
        DLY_STEP = 2'b01,
        DLY_DONE = 2'b10
    } dly_state_t;

    typedef struct packed {
        logic start;
        logic [2:0] scan_cfg;
        logic done;
        logic [11:0] zero_code;
        logic [11:0] full_code;
        logic comp_upper_trip;
        logic comp_lower_trip;
    } seq_if_t;

    typedef struct packed {
        logic manual_req;
        logic pair_done;
        logic drive_sw_dis;
        logic [1:0] meas_setting;
        logic alt_mux;
    } bal_if_t;

    typedef struct packed {
        logic [15:0] acq_cfg;
        logic [15:0] bal_dly;
        logic [3:0] irq_status;
        logic [3:0] irq_mask;
        logic [15:0] rdata;
        logic stuck_test;
        logic comp_test;
        logic cal_apply;
        logic [1:0] osr_mode;
        logic osr_tick;
        logic [19:0] osr_cnt;
        logic thermistor_bias_pin_switch;
        logic [8:0] gain;
        dly_state_t dly_state;
        logic [7:0] dly_steps;
        logic [14:0] step_cnt;
        logic dly_busy;
        logic dly_done;
        logic irq;
    } state_t;

endpackage : acq_cfg_pkg

/* design/acq_cfg.sv */
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - stuck-test enable runs converter zero/full test after every sequence except scan code 010.
// - converter test flags zero-scale if code not 000, full-scale if not fff.
// - calibration enable applies calibration to converter results only, never comparator.
// - comparator test enable tests comparator after scan codes 001 or 010.
// - comparator test flags over or under alert from bracketing threshold results.
// - rate field 00 feature-limited, 01 fixed 1.60kHz, 1x fixed 1.92kHz.
// - fixed rate paces converter and comparator scans only when oversampling above 000.
// - rate field 00 samples as fast as the sequencer allows.
// - thermistor bias: 0x closed during acquisition, 10 open, 11 closed.
// - gain field 000=4 up to 11x=256 V/V, default 4.
// - cell-path delay field is 96us per count before converter measurement.
// - manual balancing with switch-disable 1 and mux select 0 uses cell-path delay.
// - auto balancing pair with setting 1x and mux select 0 uses cell-path delay.
// - switch-path delay field is 96us per count before converter measurement.
// - manual balancing with switch-disable 1 and mux select 1 uses switch-path delay.
// - auto balancing pair with setting 1x and mux select 1 uses switch-path delay.
module acq_cfg
    import acq_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output logic irq_o,
    input wire seq_if_t seq_i,
    input wire logic acquiring_i,
    input wire logic [2:0] oversampling_setting_i,
    input wire bal_if_t bal_i,
    output logic stuck_test_o,
    output logic comp_test_o,
    output logic cal_apply_o,
    output logic [1:0] osr_mode_o,
    output logic osr_tick_o,
    output logic thermistor_bias_pin_o,
    output logic [8:0] gain_o,
    output logic dly_busy_o,
    output logic dly_done_o
);

    state_t s_r;
    state_t s_nxt;

    function automatic logic [8:0] gain_of(input logic [2:0] code);
        logic [8:0] g;
        g = 9'h004;
        if (code[2] && code[1]) begin
            g = 9'h100;
        end else begin
            g = 9'(9'h004 << code);
        end
        return g;
    endfunction : gain_of

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [3:0] set;
        logic [7:0] sel;
        logic use_sw;
        logic go;
        s_nxt = s_r;
        set = 4'h0;
        sel = 8'h00;
        use_sw = 1'b0;
        go = 1'b0;

        // register writes
        if (wr_i) begin
            if (addr_i == ACQ_CFG_ADDR) begin
                s_nxt.acq_cfg = wdata_i & ACQ_CFG_WMASK;
            end else if (addr_i == BAL_DLY_ADDR) begin
                s_nxt.bal_dly = wdata_i;
            end else if (addr_i == IRQ_MASK_ADDR) begin
                s_nxt.irq_mask = wdata_i[3:0];
            end
        end

        // reads, status cleared on read
        s_nxt.rdata = 16'h0000;
        if (rd_i) begin
            if (addr_i == ACQ_CFG_ADDR) begin
                s_nxt.rdata = s_r.acq_cfg;
            end else if (addr_i == BAL_DLY_ADDR) begin
                s_nxt.rdata = s_r.bal_dly;
            end else if (addr_i == IRQ_STATUS_ADDR) begin
                s_nxt.rdata = {12'h000, s_r.irq_status};
                s_nxt.irq_status = 4'h0;
            end else if (addr_i == IRQ_MASK_ADDR) begin
                s_nxt.rdata = {12'h000, s_r.irq_mask};
            end else if (addr_i == DIAG_STATE_ADDR) begin
                s_nxt.rdata = {14'h0000, s_r.dly_busy, s_r.thermistor_bias_pin_switch};
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // end-of-sequence diagnostics
        s_nxt.stuck_test = 1'b0;
        s_nxt.comp_test = 1'b0;
        if (seq_i.done) begin
            if (s_r.acq_cfg[STUCK_EN_BIT] && seq_i.scan_cfg != SCAN_COMP_ONLY) begin
                s_nxt.stuck_test = 1'b1;
                set[IRQ_ZS] = seq_i.zero_code != ZERO_SCALE_CODE;
                set[IRQ_FS] = seq_i.full_code != FULL_SCALE_CODE;
            end
            if (s_r.acq_cfg[COMP_EN_BIT]
                    && (seq_i.scan_cfg == SCAN_BOTH || seq_i.scan_cfg == SCAN_COMP_ONLY)) begin
                s_nxt.comp_test = 1'b1;
                set[IRQ_OV] = seq_i.comp_upper_trip;
                set[IRQ_UV] = !seq_i.comp_lower_trip;
            end
        end
        // set wins over the read clear
        s_nxt.irq_status = s_nxt.irq_status | set;

        s_nxt.cal_apply = s_r.acq_cfg[CAL_EN_BIT];

        ////////////////////////////////////////////////////////////////////////
        // oversampling pace
        s_nxt.osr_mode = s_r.acq_cfg[OSR_LSB +: 2];
        s_nxt.osr_tick = 1'b0;
        if (s_r.acq_cfg[OSR_LSB +: 2] == 2'b00 || oversampling_setting_i == 3'h0) begin
            s_nxt.osr_cnt = 20'h00000;
            s_nxt.osr_tick = 1'b1;
        end else begin
            s_nxt.osr_cnt = s_r.osr_cnt + 20'h00001;
            if (s_r.acq_cfg[OSR_LSB + 1]) begin
                if (s_r.osr_cnt >= 20'(RATE_60_CYC - 1)) begin
                    s_nxt.osr_cnt = 20'h00000;
                    s_nxt.osr_tick = 1'b1;
                end
            end else if (s_r.osr_cnt >= 20'(RATE_50_CYC - 1)) begin
                s_nxt.osr_cnt = 20'h00000;
                s_nxt.osr_tick = 1'b1;
            end
        end

        // thermistor bias switch
        case (s_r.acq_cfg[THERMISTOR_BIAS_PIN_LSB +: 2])
            2'b10: s_nxt.thermistor_bias_pin_switch = 1'b0;
            2'b11: s_nxt.thermistor_bias_pin_switch = 1'b1;
            default: s_nxt.thermistor_bias_pin_switch = acquiring_i;
        endcase

        s_nxt.gain = gain_of(s_r.acq_cfg[GAIN_LSB +: 3]);

        ////////////////////////////////////////////////////////////////////////
        // balancing recovery delay
        if (bal_i.manual_req && bal_i.drive_sw_dis) begin
            go = 1'b1;
        end
        if (bal_i.pair_done && bal_i.meas_setting[1]) begin
            go = 1'b1;
        end
        use_sw = bal_i.alt_mux;
        sel = use_sw ? s_r.bal_dly[7:0] : s_r.bal_dly[15:8];

        s_nxt.dly_done = 1'b0;
        case (s_r.dly_state)
            DLY_IDLE: begin
                if (go) begin
                    s_nxt.dly_steps = sel;
                    s_nxt.step_cnt = 15'h0000;
                    s_nxt.dly_busy = 1'b1;
                    s_nxt.dly_state = (sel == 8'h00) ? DLY_DONE : DLY_STEP;
                end
            end
            DLY_STEP: begin
                if (s_r.step_cnt == 15'(STEP_CYC - 1)) begin
                    s_nxt.step_cnt = 15'h0000;
                    s_nxt.dly_steps = s_r.dly_steps - 8'h01;
                    if (s_r.dly_steps == 8'h01) begin
                        s_nxt.dly_state = DLY_DONE;
                    end
                end else begin
                    s_nxt.step_cnt = s_r.step_cnt + 15'h0001;
                end
            end
            DLY_DONE: begin
                s_nxt.dly_busy = 1'b0;
                s_nxt.dly_done = 1'b1;
                s_nxt.dly_state = DLY_IDLE;
            end
            default: s_nxt.dly_state = DLY_IDLE;
        endcase

        s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_r <= '{
                acq_cfg: ACQ_CFG_RESET,
                bal_dly: BAL_DLY_RESET,
                irq_status: 4'h0,
                irq_mask: 4'h0,
                rdata: 16'h0000,
                stuck_test: 1'b0,
                comp_test: 1'b0,
                cal_apply: 1'b0,
                osr_mode: 2'b00,
                osr_tick: 1'b0,
                osr_cnt: 20'h00000,
                thermistor_bias_pin_switch: 1'b0,
                gain: 9'h004,
                dly_state: DLY_IDLE,
                dly_steps: 8'h00,
                step_cnt: 15'h0000,
                dly_busy: 1'b0,
                dly_done: 1'b0,
                irq: 1'b0
            };
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign irq_o = s_r.irq;
    assign stuck_test_o = s_r.stuck_test;
    assign comp_test_o = s_r.comp_test;
    assign cal_apply_o = s_r.cal_apply;
    assign osr_mode_o = s_r.osr_mode;
    assign osr_tick_o = s_r.osr_tick;
    assign thermistor_bias_pin_o = s_r.thermistor_bias_pin_switch;
    assign gain_o = s_r.gain;
    assign dly_busy_o = s_r.dly_busy;
    assign dly_done_o = s_r.dly_done;

endmodule : acq_cfg

/* testbench/acq_cfg_chk.sv */
`timescale 1ns/1ps
module acq_cfg_chk
    import acq_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire seq_if_t seq_i,
    input wire logic stuck_test_o,
    input wire logic comp_test_o,
    input wire logic cal_apply_o,
    input wire logic [1:0] osr_mode_o,
    input wire logic thermistor_bias_pin_o,
    input wire logic [8:0] gain_o
);
    logic [15:0] cfg_r;
    logic [8:0] gain_exp;
    logic cmp_scan;
    logic stk_go;
    assign gain_exp = (cfg_r[8:7] == 2'b11) ? 9'h100 : 9'h004 << cfg_r[8:6];
    assign cmp_scan = seq_i.scan_cfg == SCAN_BOTH || seq_i.scan_cfg == SCAN_COMP_ONLY;
    assign stk_go = cfg_r[15] && seq_i.scan_cfg != SCAN_COMP_ONLY;
    // shadow of the configuration word with the write mask applied
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cfg_r <= 16'h0000;
        end else if (wr_i && addr_i == ACQ_CFG_ADDR) begin
            cfg_r <= wdata_i & ACQ_CFG_WMASK;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_STUCK_ON: assert property (seq_i.done && stk_go |=> stuck_test_o)
        else $error("stuck test missing");
    AST_STUCK_OFF: assert property (seq_i.done && !stk_go |=> !stuck_test_o)
        else $error("stuck test unexpected");
    AST_COMP_ON: assert property (seq_i.done && cfg_r[13] && cmp_scan |=> comp_test_o)
        else $error("comparator test missing");
    AST_COMP_OFF: assert property (seq_i.done && !(cfg_r[13] && cmp_scan) |=> !comp_test_o)
        else $error("comparator test unexpected");
    AST_CAL: assert property ($stable(cfg_r)[*3] |-> cal_apply_o == cfg_r[14])
        else $error("calibration output wrong");
    AST_OSR: assert property ($stable(cfg_r)[*3] |-> osr_mode_o == cfg_r[12:11])
        else $error("rate mode wrong");
    AST_THERMISTOR_BIAS_PIN: assert property ($stable(cfg_r)[*3] && cfg_r[10]
        |-> thermistor_bias_pin_o == cfg_r[9])
        else $error("bias switch wrong");
    AST_GAIN: assert property ($stable(cfg_r)[*3] |-> gain_o == gain_exp)
        else $error("gain wrong");
    AST_UNUSED: assert property (rd_i && addr_i == ACQ_CFG_ADDR
        |=> rdata_o[5:0] == 6'h00 && rdata_o == $past(cfg_r))
        else $error("unused bits not zero");
endmodule : acq_cfg_chk

bind acq_cfg acq_cfg_chk chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .seq_i(seq_i),
    .stuck_test_o(stuck_test_o), .comp_test_o(comp_test_o), .cal_apply_o(cal_apply_o),
    .osr_mode_o(osr_mode_o), .thermistor_bias_pin_o(thermistor_bias_pin_o), .gain_o(gain_o));

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top
    import acq_cfg_pkg::*;
;
    logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, acquiring_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [2:0] ovs_i = 3'h1;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    seq_if_t seq_i = '0;
    bal_if_t bal_i = '0;
    logic irq_o, stuck_test_o, comp_test_o, cal_apply_o, osr_tick_o, pin_o, busy_o, done_o;
    logic [1:0] osr_mode_o;
    logic [8:0] gain_o;
    int n_errors = 0;
    int num_checks = 0;
    acq_cfg dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .seq_i(seq_i),
        .acquiring_i(acquiring_i), .oversampling_setting_i(ovs_i), .bal_i(bal_i),
        .stuck_test_o(stuck_test_o), .comp_test_o(comp_test_o), .cal_apply_o(cal_apply_o),
        .osr_mode_o(osr_mode_o), .osr_tick_o(osr_tick_o), .thermistor_bias_pin_o(pin_o),
        .gain_o(gain_o), .dly_busy_o(busy_o), .dly_done_o(done_o));
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, e, rdata_o);
    endtask : rc
    task automatic seqp(input logic [2:0] s, input logic [11:0] z, input logic [11:0] f,
        input logic up, input logic lo, input logic [1:0] e);
        @(posedge clk_i);
        seq_i <= '{1'b0, s, 1'b1, z, f, up, lo};
        @(posedge clk_i);
        seq_i.done <= 1'b0;
        #1;
        chk("tests", {14'h0, e}, {14'h0, stuck_test_o, comp_test_o});
    endtask : seqp
    task automatic dly(input logic [1:0] p, input logic be, input int lim, output int n);
        @(posedge clk_i);
        bal_i.manual_req <= p[1];
        bal_i.pair_done <= p[0];
        @(posedge clk_i);
        bal_i.manual_req <= 1'b0;
        bal_i.pair_done <= 1'b0;
        n = 0;
        #1;
        chk("busy", {15'h0, be}, {15'h0, busy_o});
        while (done_o !== 1'b1 && n < lim) begin
            tick(1);
            n++;
        end
    endtask : dly
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        chk("gain_rst", 16'h0004, {7'h0, gain_o});
        rc(ACQ_CFG_ADDR, 16'h0000, "acq_rst");
        wr(ACQ_CFG_ADDR, 16'hffff);
        rc(ACQ_CFG_ADDR, 16'hffc0, "acq");
        wr(BAL_DLY_ADDR, 16'ha55a);
        rc(BAL_DLY_ADDR, 16'ha55a, "bal");
        wr(8'h10, 16'hffff);
        rc(8'h10, 16'h0000, "unmapped");
        wr(ACQ_CFG_ADDR, 16'h4800);
        tick(3);
        chk("cal_osr", 16'h0005, {13'h0, cal_apply_o, osr_mode_o});
        wr(ACQ_CFG_ADDR, 16'h1000);
        tick(3);
        chk("cal_osr", 16'h0002, {13'h0, cal_apply_o, osr_mode_o});
    endtask : t_regs
    task automatic t_osr();
        int n;
        n = 0;
        wr(ACQ_CFG_ADDR, 16'h0000);
        tick(3);
        chk("tick_free", 16'h0001, {15'h0, osr_tick_o});
        wr(ACQ_CFG_ADDR, 16'h0800);
        tick(2);
        for (int i = 0; i < 200; i++) begin
            tick(1);
            n += int'(osr_tick_o);
        end
        chk("tick_50", 16'h0000, 16'(n));
        @(posedge clk_i);
        ovs_i <= 3'h0;
        tick(3);
        chk("tick_ovs0", 16'h0001, {15'h0, osr_tick_o});
        @(posedge clk_i);
        ovs_i <= 3'h1;
    endtask : t_osr
    task automatic t_gain();
        for (int g = 0; g < 8; g++) begin
            wr(ACQ_CFG_ADDR, 16'(g) << 6);
            tick(3);
            chk("gain", (g > 5) ? 16'h0100 : 16'h0004 << g, {7'h0, gain_o});
        end
    endtask : t_gain
    task automatic t_thermistor_bias_pin();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_i);
            acquiring_i <= i[0];
            wr(ACQ_CFG_ADDR, 16'(i[2:1]) << 9);
            tick(3);
            chk("thermistor_bias_pin", i[2] ? 16'(i[1]) : 16'(i[0]), {15'h0, pin_o});
            rc(DIAG_STATE_ADDR, i[2] ? 16'(i[1]) : 16'(i[0]), "diag");
        end
    endtask : t_thermistor_bias_pin
    task automatic t_diag();
        wr(IRQ_MASK_ADDR, 16'h000f);
        wr(ACQ_CFG_ADDR, 16'ha000);
        seqp(3'h0, 12'h000, 12'hfff, 1'b0, 1'b1, 2'b10);
        seqp(3'h2, 12'h005, 12'h000, 1'b0, 1'b1, 2'b01);
        seqp(3'h4, 12'h000, 12'hfff, 1'b0, 1'b1, 2'b10);
        rc(IRQ_STATUS_ADDR, 16'h0000, "status");
        seqp(3'h1, 12'h001, 12'hffe, 1'b1, 1'b0, 2'b11);
        chk("irq", 16'h0001, {15'h0, irq_o});
        rc(IRQ_STATUS_ADDR, 16'h000f, "status");
        rc(IRQ_STATUS_ADDR, 16'h0000, "status");
        chk("irq", 16'h0000, {15'h0, irq_o});
        wr(IRQ_MASK_ADDR, 16'h0000);
        seqp(3'h1, 12'h001, 12'hffe, 1'b1, 1'b0, 2'b11);
        chk("irq", 16'h0000, {15'h0, irq_o});
        rc(IRQ_STATUS_ADDR, 16'h000f, "status");
    endtask : t_diag
    task automatic t_dly();
        int n;
        wr(BAL_DLY_ADDR, 16'h0100);
        bal_i <= '{1'b0, 1'b0, 1'b1, 2'b00, 1'b1};
        dly(2'b10, 1'b1, 30000, n);
        chk("sw_dly", 16'h0001, 16'(n < 10));
        @(posedge clk_i);
        bal_i.alt_mux <= 1'b0;
        dly(2'b10, 1'b1, 30000, n);
        chk("cell_dly", 16'h0001, 16'(n / STEP_CYC));
        @(posedge clk_i);
        bal_i <= '{1'b0, 1'b0, 1'b0, 2'b10, 1'b1};
        dly(2'b01, 1'b1, 30000, n);
        chk("sw_dly", 16'h0001, 16'(n < 10));
        @(posedge clk_i);
        bal_i.alt_mux <= 1'b0;
        dly(2'b01, 1'b1, 30000, n);
        chk("cell_dly", 16'h0001, 16'(n / STEP_CYC));
        @(posedge clk_i);
        bal_i.meas_setting <= 2'b01;
        dly(2'b11, 1'b0, 20, n);
        chk("no_dly", 16'h0000, {15'h0, busy_o});
    endtask : t_dly
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : test_done
    initial begin
        #(80000 * 5);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        reset_n_i <= 1'b1;
        tick(1);
        t_regs();
        t_osr();
        t_gain();
        t_thermistor_bias_pin();
        t_diag();
        t_dly();
        test_done();
    end
endmodule : tb_top
